// [src/i2cm_pkg.sv]
// constants, types and register map of the buffered i2c master
package i2cm_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_ADR = 8'h04;
  localparam logic [7:0] OFF_WTOT = 8'h08;
  localparam logic [7:0] OFF_RTOT = 8'h0c;
  localparam logic [7:0] OFF_CHUNK = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  localparam logic [7:0] OFF_OUTW = 8'h1c;
  localparam logic [7:0] OFF_INW = 8'h20;
  localparam logic [7:0] OFF_RATE = 8'h24;
  localparam logic [7:0] OFF_MOVED = 8'h28;
  // ----------------------------------------
  // control bits and reset values
  // ----------------------------------------
  localparam int CTL_BEGIN = 0;
  localparam int CTL_COMMIT = 1;
  localparam int CTL_CONSUMED = 2;
  localparam int CTL_CLEAR = 3;
  localparam int CTL_CANCEL = 4;
  localparam logic [31:0] CFG_RST = 32'h0000_0d80;
  localparam logic [7:0] CHUNK_RST = 8'h10;
  localparam logic [4:0] BUF_BYTES = 5'h10;
  localparam logic [7:0] LEAD_BYTE = 8'h01;
  localparam logic [4:0] TEN_BIT_HDR = 5'h1e;
  // ----------------------------------------
  // timing: bus rates in khz, lockup times in us
  // ----------------------------------------
  localparam int RATE_KHZ [8] = '{10, 100, 400, 1000, 18, 170, 670, 1700};
  localparam int unsigned LOCKUP_US [16] = '{500, 1000, 2000, 5000, 10000, 20000,
    30000, 40000, 50000, 60000, 70000, 80000, 90000, 100000, 100000, 100000};
  localparam int KHZ_PER_CODE_NUM = 125;
  localparam int KHZ_PER_CODE_DEN = 8;
  localparam int MIN_CLK_PER_BIT = 8;
  localparam logic [15:0] BAND_LO [5] = '{16'h20d0, 16'h1062, 16'h0831, 16'h041a, 16'h020d};
  localparam logic [15:0] BAND_HI [5] = '{16'h2580, 16'h12c0, 16'h0960, 16'h04b0, 16'h0258};
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_START = 3'b001, S_BITS = 3'b011,
    S_WAITD = 3'b010, S_STOP = 3'b110, S_PARK = 3'b111
  } state_t;
  typedef enum logic [2:0] {K_LEAD, K_ADRHI, K_ADRLO, K_ADRRD, K_DATA} kind_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avs_req_t;
endpackage

// [src/i2c_master_buffered.sv]
// buffered i2c bus master with avalon-mm register slave
// Functional notes
// - scl rate derived from the clock, select picks 10k/100k/400k/1M
// - status flag shows the stated clock rate too low for chosen speed
// - clock code inside listed bands selects faster rates 18k/170k/670k/1.7M
// - target address sent in 7 or 10 bit form, r/w bit inserted
// - stop after transfer or nack unless keep bits ask for repeated start
// - optional lead byte sent before address of every transaction
// - clock held low beyond timeout sets lockup flag and event
// - lost contention aborts or retries up to the configured count
// - 16-byte outgoing and incoming buffers, separate byte totals
// - commit marks data ready; space flag; scl held until committed
// - data flag when block received; scl held until consumed
// - transfers split into blocks of programmable size, at most 16
// - surplus bytes of last word in a block are ignored
// - byte order within a word follows the order setting
// - begin starts a transfer; first block may be committed before or after
// - cancel stops any ongoing transaction
// - active flag during a transaction, byte count reported
// - event per completed block and per transaction, errors included
// - separate flags for nack, lockup and lost contention
// - error flags sticky until next transaction begins
// - 7-bit mode uses low seven address bits only
// - while cancel stays set no bus activity starts
//
// Chosen here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_buffered #(
  parameter int unsigned CLK_KHZ = 250000
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // register bus
  input wire i2cm_pkg::avs_req_t avs_req_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // bus pins, enables low while pulling the line low
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // event pulses
  output logic block_event_o,
  output logic done_event_o,
  output logic lockup_event_o
);
  import i2cm_pkg::*;

  // ----------------------------------------
  // derived counts
  // ----------------------------------------
  function automatic logic [19:0] qc(input int r);
    int unsigned v;
    v = (CLK_KHZ + 4 * r - 1) / (4 * r);
    return 20'((v < 1) ? 1 : v);
  endfunction
  localparam logic [19:0] QTAB [8] = '{qc(RATE_KHZ[0]), qc(RATE_KHZ[1]), qc(RATE_KHZ[2]),
    qc(RATE_KHZ[3]), qc(RATE_KHZ[4]), qc(RATE_KHZ[5]), qc(RATE_KHZ[6]), qc(RATE_KHZ[7])};
  localparam logic [15:0] US_CYC = 16'((CLK_KHZ + 999) / 1000);
  localparam logic [15:0] CODE_RST = 16'(CLK_KHZ * KHZ_PER_CODE_DEN / KHZ_PER_CODE_NUM);

  function automatic logic [1:0] lane(input logic [1:0] ord, input logic [1:0] k);
    case (ord)
      2'b01: return k ^ 2'b01;
      2'b10: return 2'b11 - k;
      default: return k;
    endcase
  endfunction
  function automatic logic [4:0] csize(input logic [7:0] s);
    if (s == 8'h00) return 5'h01;
    if (s > 8'(BUF_BYTES)) return BUF_BYTES;
    return s[4:0];
  endfunction
  function automatic logic [20:0] tot(input logic [20:0] t);
    return (t == 21'h0) ? 21'h1 : t;
  endfunction

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [31:0] cfg;
    logic [9:0] tgt;
    logic [9:0] maxr;
    logic [20:0] wtot;
    logic [20:0] rtot;
    logic [7:0] wch;
    logic [7:0] rch;
    logic [15:0] code;
    logic cancel;
    logic active;
    logic nack_f;
    logic lock_f;
    logic arb_f;
    logic [20:0] moved;
    logic [3:0][31:0] txm;
    logic [3:0][31:0] rxm;
    logic [1:0] twp;
    logic [1:0] rrp;
    logic tfull;
    logic rfull;
    state_t st;
    kind_t kind;
    logic [1:0] ph;
    logic [19:0] tick;
    logic [3:0] bitn;
    logic [8:0] sh;
    logic [4:0] blk;
    logic [9:0] tries;
    logic [15:0] us;
    logic [16:0] wd;
    logic scl_oe_n;
    logic sda_oe_n;
    logic bwait;
    logic [31:0] rdata;
    logic blk_ev;
    logic done_ev;
    logic lock_ev;
  } regs_t;
  regs_t q, d;

  // config field aliases
  logic [2:0] spd;
  logic a10, keepx, keepn, lead, mon, wdt_en, dir, retry;
  logic [3:0] wsel;
  logic [1:0] ord;
  assign spd = q.cfg[2:0];
  assign a10 = q.cfg[3];
  assign keepx = q.cfg[4];
  assign keepn = q.cfg[5];
  assign lead = q.cfg[6];
  assign mon = q.cfg[7];
  assign wdt_en = q.cfg[8];
  assign wsel = q.cfg[12:9];
  assign dir = q.cfg[13];
  assign ord = q.cfg[15:14];
  assign retry = q.cfg[16];

  // ----------------------------------------
  // speed selection and clock checks
  // ----------------------------------------
  logic band, slow;
  logic [2:0] ridx;
  always_comb begin
    band = 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (q.code >= BAND_LO[i] && q.code <= BAND_HI[i]) band = 1'b1;
    end
    ridx = {band, (spd[2] ? 2'b00 : spd[1:0])};
    slow = (24'(q.code) * 24'(KHZ_PER_CODE_NUM)) <
      (24'(RATE_KHZ[ridx]) * 24'(KHZ_PER_CODE_DEN * MIN_CLK_PER_BIT));
  end

  logic wr, rd, run, strch, step, lastb, cend, sda_hi, scl_hi, nk;
  logic [7:0] addr, txb;
  logic [31:0] wdat;
  logic [20:0] total;
  logic [4:0] chunk;
  assign addr = avs_req_i.address;
  assign wr = avs_req_i.write && !q.bwait;
  assign rd = avs_req_i.read && !q.bwait;
  assign scl_hi = q.scl_s[1];
  assign sda_hi = q.sda_s[1];
  assign total = dir ? tot(q.rtot) : tot(q.wtot);
  assign chunk = dir ? csize(q.rch) : csize(q.wch);
  assign lastb = (q.moved + 21'h1) >= total;
  assign cend = (q.blk + 5'h1) >= chunk;
  assign txb = q.txm[q.blk[3:2]][{lane(ord, q.blk[1:0]), 3'b000} +: 8];
  assign nk = q.sh[0];
  always_comb begin
    wdat = q.cfg;
    for (int b = 0; b < 4; b++) begin
      if (avs_req_i.byteenable[b]) wdat[8*b +: 8] = avs_req_i.writedata[8*b +: 8];
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.scl_s = {q.scl_s[0], scl_i};
    d.sda_s = {q.sda_s[0], sda_i};
    d.blk_ev = 1'b0;
    d.done_ev = 1'b0;
    d.lock_ev = 1'b0;
    // one wait state: data latched on the first edge, taken on the second
    if ((avs_req_i.read || avs_req_i.write) && q.bwait) begin
      d.bwait = 1'b0;
      case (addr)
        OFF_CFG: d.rdata = q.cfg;
        OFF_ADR: d.rdata = {6'h0, q.maxr, 6'h0, q.tgt};
        OFF_WTOT: d.rdata = {11'h0, q.wtot};
        OFF_RTOT: d.rdata = {11'h0, q.rtot};
        OFF_CHUNK: d.rdata = {16'h0, q.rch, q.wch};
        OFF_CTRL: d.rdata = {27'h0, q.cancel, 4'h0};
        OFF_STAT: d.rdata = {25'h0, slow, q.arb_f, q.lock_f, q.nack_f,
          q.rfull, !q.tfull, q.active};
        OFF_INW: d.rdata = q.rxm[q.rrp];
        OFF_RATE: d.rdata = {16'h0, q.code};
        OFF_MOVED: d.rdata = {11'h0, q.moved};
        default: d.rdata = 32'h0;
      endcase
    end else begin
      d.bwait = 1'b1;
    end
    if (rd && addr == OFF_INW) d.rrp = q.rrp + 2'h1;
    if (wr) begin
      case (addr)
        OFF_CFG: d.cfg = wdat;
        OFF_ADR: begin
          d.tgt = wdat[9:0];
          d.maxr = wdat[25:16];
        end
        OFF_WTOT: d.wtot = wdat[20:0];
        OFF_RTOT: d.rtot = wdat[20:0];
        OFF_CHUNK: begin
          d.wch = wdat[7:0];
          d.rch = wdat[15:8];
        end
        OFF_RATE: d.code = wdat[15:0];
        OFF_OUTW: begin
          d.txm[q.twp] = wdat;
          d.twp = q.twp + 2'h1;
        end
        OFF_CTRL: if (avs_req_i.byteenable[0]) begin
          d.cancel = wdat[CTL_CANCEL];
          if (wdat[CTL_COMMIT]) d.tfull = 1'b1;
          if (wdat[CTL_CONSUMED]) begin
            d.rfull = 1'b0;
            d.rrp = 2'h0;
          end
          if (wdat[CTL_CLEAR]) begin
            d.tfull = 1'b0;
            d.rfull = 1'b0;
            d.twp = 2'h0;
            d.rrp = 2'h0;
          end
          if (wdat[CTL_BEGIN] && !wdat[CTL_CANCEL] && !q.cancel &&
              (q.st == S_IDLE || q.st == S_PARK)) begin
            d.active = 1'b1;
            d.nack_f = 1'b0;
            d.lock_f = 1'b0;
            d.arb_f = 1'b0;
            d.moved = 21'h0;
            d.blk = 5'h0;
            d.tries = 10'h0;
            d.kind = lead ? K_LEAD : K_ADRHI;
            d.st = S_START;
            d.ph = 2'h0;
            d.tick = 20'h0;
          end
        end
        default: ;
      endcase
    end
    // bus engine, quarter-bit steps
    run = (q.st == S_START || q.st == S_BITS || q.st == S_STOP);
    strch = run && q.ph == 2'h2 && mon && !scl_hi;
    step = 1'b0;
    if (run && !strch) begin
      if (q.tick != 20'h0) begin
        d.tick = q.tick - 20'h1;
      end else begin
        d.tick = QTAB[ridx] - 20'h1;
        step = 1'b1;
      end
    end
    d.us = 16'h0;
    d.wd = 17'h0;
    if (strch && wdt_en) begin
      d.us = (q.us == US_CYC - 16'h1) ? 16'h0 : q.us + 16'h1;
      d.wd = (q.us == US_CYC - 16'h1) ? q.wd + 17'h1 : q.wd;
    end
    if (strch && wdt_en && 32'(q.wd) >= LOCKUP_US[wsel]) begin
      d.lock_f = 1'b1;
      d.lock_ev = 1'b1;
      d.done_ev = 1'b1;
      d.active = 1'b0;
      d.st = S_IDLE;
      d.scl_oe_n = 1'b1;
      d.sda_oe_n = 1'b1;
    end else if (step) begin
      d.ph = q.ph + 2'h1;
      case (q.st)
        S_START: case (q.ph)
          2'h0: d.sda_oe_n = 1'b1;
          2'h1: d.scl_oe_n = 1'b1;
          2'h2: d.sda_oe_n = 1'b0;
          default: begin
            d.scl_oe_n = 1'b0;
            d.st = S_BITS;
            d.bitn = 4'h0;
            case (q.kind)
              K_LEAD: d.sh = {LEAD_BYTE, 1'b1};
              K_ADRRD: d.sh = {TEN_BIT_HDR, q.tgt[9:8], 1'b1, 1'b1};
              default: d.sh = a10 ? {TEN_BIT_HDR, q.tgt[9:8], 1'b0, 1'b1}
                : {q.tgt[6:0], dir, 1'b1};
            endcase
          end
        endcase
        S_STOP: case (q.ph)
          2'h0: d.sda_oe_n = 1'b0;
          2'h1: d.scl_oe_n = 1'b1;
          2'h2: d.sda_oe_n = 1'b1;
          default: begin
            d.st = S_IDLE;
            d.active = 1'b0;
          end
        endcase
        S_BITS: case (q.ph)
          2'h0: d.sda_oe_n = q.sh[8];
          2'h1: d.scl_oe_n = 1'b1;
          2'h2: begin
            d.sh = {q.sh[7:0], sda_hi};
            if (q.sh[8] && !sda_hi && q.bitn < 4'h8 && !(q.kind == K_DATA && dir)) begin
              d.scl_oe_n = 1'b1;
              d.sda_oe_n = 1'b1;
              d.ph = 2'h0;
              if (retry && q.tries < q.maxr) begin
                d.tries = q.tries + 10'h1;
                d.kind = lead ? K_LEAD : K_ADRHI;
                d.st = S_START;
              end else begin
                d.arb_f = 1'b1;
                d.done_ev = 1'b1;
                d.active = 1'b0;
                d.st = S_IDLE;
              end
            end
          end
          default: begin
            d.scl_oe_n = 1'b0;
            d.bitn = q.bitn + 4'h1;
            if (q.bitn == 4'h8) begin
              d.st = S_WAITD;
              if (q.kind == K_LEAD) begin
                d.st = S_START;
                d.kind = K_ADRHI;
              end else if (nk && !(q.kind == K_DATA && dir)) begin
                d.nack_f = 1'b1;
                d.done_ev = 1'b1;
                d.st = keepn ? S_PARK : S_STOP;
                d.active = !keepn;
              end else if (q.kind == K_ADRHI && a10) begin
                d.st = S_BITS;
                d.bitn = 4'h0;
                d.kind = K_ADRLO;
                d.sh = {q.tgt[7:0], 1'b1};
              end else if (q.kind == K_ADRLO && dir) begin
                d.st = S_START;
                d.kind = K_ADRRD;
              end else if (q.kind != K_DATA) begin
                d.kind = K_DATA;
              end else begin
                if (dir) d.rxm[q.blk[3:2]][{lane(ord, q.blk[1:0]), 3'b000} +: 8] = q.sh[8:1];
                d.moved = q.moved + 21'h1;
                d.blk = q.blk + 5'h1;
                if (cend || lastb) begin
                  d.blk = 5'h0;
                  d.blk_ev = 1'b1;
                  if (dir) d.rfull = 1'b1;
                  else d.tfull = 1'b0;
                end
                if (lastb) begin
                  d.done_ev = 1'b1;
                  d.st = keepx ? S_PARK : S_STOP;
                  d.active = !keepx;
                end
              end
            end
          end
        endcase
        default: ;
      endcase
    end
    // scl stays low here until the buffer side is ready
    if (q.st == S_WAITD) begin
      if (dir ? !q.rfull : q.tfull) begin
        d.st = S_BITS;
        d.ph = 2'h0;
        d.bitn = 4'h0;
        d.sh = dir ? {8'hff, lastb} : {txb, 1'b1};
      end
    end
    if (q.cancel && q.st != S_IDLE) begin
      d.st = S_IDLE;
      d.active = 1'b0;
      d.scl_oe_n = 1'b1;
      d.sda_oe_n = 1'b1;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
      q.scl_s <= 2'b11;
      q.sda_s <= 2'b11;
      q.cfg <= CFG_RST;
      q.wch <= CHUNK_RST;
      q.rch <= CHUNK_RST;
      q.code <= CODE_RST;
      q.st <= S_IDLE;
      q.kind <= K_ADRHI;
      q.scl_oe_n <= 1'b1;
      q.sda_oe_n <= 1'b1;
      q.bwait <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign avs_readdata_o = q.rdata;
  assign avs_waitrequest_o = q.bwait;
  assign scl_o = q.cfg[31] & 1'b0;
  assign sda_o = q.cfg[31] & 1'b0;
  assign scl_oe_n_o = q.scl_oe_n;
  assign sda_oe_n_o = q.sda_oe_n;
  assign block_event_o = q.blk_ev;
  assign done_event_o = q.done_ev;
  assign lockup_event_o = q.lock_ev;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic go;
  assign go = wr && addr == OFF_CTRL && avs_req_i.byteenable[0] && avs_req_i.writedata[CTL_BEGIN]
    && !avs_req_i.writedata[CTL_CANCEL] && !q.cancel && (q.st == S_IDLE || q.st == S_PARK);
  sequence begun_s;
    q.active && q.st == S_START && q.ph == 2'h0;
  endsequence
  sequence clean_s;
    !q.nack_f && !q.lock_f && !q.arb_f;
  endsequence
  begin_active_a: assert property (go |=> begun_s) else $error("begin not taken");
  flags_cleared_a: assert property (go |=> clean_s) else $error("error flags kept");
  lead_first_a: assert property (go && lead |=> q.kind == K_LEAD) else $error("lead byte skipped");
  cancel_halts_a: assert property (q.cancel |=> q.st == S_IDLE [*2] or !q.cancel)
    else $error("activity under cancel");
  hold_low_a: assert property (q.st == S_WAITD |-> !q.scl_oe_n) else $error("clock released");
  chunk_bound_a: assert property (q.blk < BUF_BYTES) else $error("block overrun");
  lockup_cause_a: assert property (q.lock_ev |-> q.lock_f && q.done_ev && mon && wdt_en)
    else $error("lockup without cause");
  contention_end_a: assert property ($rose(q.arb_f) |-> !retry || q.tries >= q.maxr)
    else $error("abort before retries used");
  stop_policy_a: assert property (q.done_ev && !q.lock_f && !q.arb_f && !q.cancel |->
    q.st == ((q.nack_f ? keepn : keepx) ? S_PARK : S_STOP)) else $error("wrong end");
  rx_flag_a: assert property (q.rfull && q.st == S_WAITD && dir |=> q.st == S_WAITD || q.cancel)
    else $error("read with full buffer");
endmodule // i2c_master_buffered
`default_nettype wire

// [sim/i2c_target_model.sv]
// behavioural i2c target that sits on the far side of the master
`timescale 1ns/1ps
`default_nettype none
module i2c_target_model #(
  parameter logic [6:0] ADDR = 7'h5a
) (
  // bus lines, outputs high mean released
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_rel_o,
  output logic sda_rel_o,
  // fault controls from the bench
  input wire logic nack_i,
  input wire logic hold_scl_i
);
  logic [7:0] sh = 8'h00;
  logic [7:0] rd_byte = 8'hc0;
  logic adr = 1'b0;
  logic sel = 1'b0;
  logic rd = 1'b0;
  int bitn = 0;
  logic [7:0] rx_q[$];
  initial sda_rel_o = 1'b1;
  // stretching from outside, used for the lockup case
  assign scl_rel_o = !hold_scl_i;
  // start or repeated start
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    bitn = -1;
    adr = 1'b1;
    sel = 1'b0;
  end
  // stop
  always @(posedge sda_i) if (scl_i === 1'b1) begin
    adr = 1'b0;
    sel = 1'b0;
  end
  always @(posedge scl_i) begin
    if (bitn < 8) sh = {sh[6:0], sda_i};
    else if (rd && sda_i) sel = 1'b0;
  end
  // data only changes while the clock is low
  always @(negedge scl_i) begin
    sda_rel_o = 1'b1;
    bitn = (bitn == 8) ? 0 : bitn + 1;
    if (bitn == 8) begin
      if (adr) begin
        sel = (sh[7:1] == ADDR);
        rd = sh[0];
        adr = 1'b0;
        rd_byte = 8'hc0;
        sda_rel_o = !sel;
      end else if (sel && !rd) begin
        rx_q.push_back(sh);
        sda_rel_o = nack_i;
      end
    end else if (sel && rd) begin
      sda_rel_o = rd_byte[7-bitn];
      if (bitn == 7) rd_byte = rd_byte + 8'h01;
    end
  end
endmodule // i2c_target_model
`default_nettype wire

// [sim/i2c_master_buffered_bench.sv]
// self-checking bench for the buffered i2c master
`timescale 1ns/1ps
`default_nettype none
module i2c_master_buffered_bench;
  import i2cm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  avs_req_t req = '0;
  logic [31:0] rdata;
  logic wreq, scl_oe_n, sda_oe_n, blk_ev, done_ev, lock_ev, scl_rel, sda_rel;
  logic nack = 1'b0;
  logic hold = 1'b0;
  logic clash = 1'b0;
  wire scl_w;
  wire sda_w;
  int fail_count = 0;
  int samples_checked = 0;
  int blocks = 0;
  int dones = 0;
  int locks = 0;
  // open drain lines with pull-up
  assign scl_w = scl_oe_n & scl_rel;
  // clash stands in for a second master pulling data low
  assign sda_w = sda_oe_n & sda_rel & !clash;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (blk_ev === 1'b1) blocks <= blocks + 1;
    if (done_ev === 1'b1) dones <= dones + 1;
    if (lock_ev === 1'b1) locks <= locks + 1;
  end
  i2c_master_buffered #(.CLK_KHZ(6400)) i2c_master_buffered_inst (.clock_i(clk), .reset_i(rst),
    .avs_req_i(req), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .scl_i(scl_w), .scl_o(),
    .scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(), .sda_oe_n_o(sda_oe_n), .block_event_o(blk_ev),
    .done_event_o(done_ev), .lockup_event_o(lock_ev));
  i2c_target_model i2c_target_model_inst (.scl_i(scl_w), .sda_i(sda_w), .scl_rel_o(scl_rel),
    .sda_rel_o(sda_rel), .nack_i(nack), .hold_scl_i(hold));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bail();
    fail_count++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    report_and_stop();
  endtask
  // avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hf};
    do begin
      @(posedge clk);
      n++;
      if (n > 50) bail();
    end while (wreq !== 1'b0);
    q = rdata;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q & m, e);
  endtask
  task automatic wait_cnt(ref int cnt, input int target, input int lim);
    for (int i = 0; cnt < target; i++) begin
      if (i > lim) bail();
      @(posedge clk);
    end
  endtask
  // done comes at the last byte, the stop follows later
  task automatic wait_idle();
    logic [31:0] s;
    for (int i = 0; i < 200; i++) begin
      bus(1'b0, OFF_STAT, 32'h0, s);
      if (s[0] === 1'b0) return;
    end
    bail();
  endtask
  task automatic setup(input logic [31:0] cfg, input logic [7:0] n, input logic [31:0] w0);
    wr(OFF_CFG, cfg);
    wr(OFF_ADR, 32'h0000_03da);
    wr(OFF_WTOT, {24'h0, n});
    wr(OFF_RTOT, {24'h0, n});
    wr(OFF_CHUNK, {16'h0, 8'h04, n});
    wr(OFF_CTRL, 32'h08);
    wr(OFF_OUTW, w0);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd_chk(OFF_CFG, 32'hffff_ffff, CFG_RST);
    rd_chk(OFF_CHUNK, 32'hffff, 32'h1010);
    rd_chk(OFF_STAT, 32'h3f, 32'h02);
    rd_chk(8'h3c, 32'hffff_ffff, 32'h0);
    wr(OFF_CFG, 32'h0000_0183);
    rd_chk(OFF_STAT, 32'h40, 32'h40);
    wr(OFF_CFG, 32'h0000_0181);
    rd_chk(OFF_STAT, 32'h40, 32'h00);
  endtask
  task automatic run_write(input logic [31:0] cfg, input logic [7:0] n, input logic [63:0] w,
      input logic [63:0] exp, input logic early);
    int b0;
    int k0;
    b0 = dones;
    k0 = blocks;
    i2c_target_model_inst.rx_q.delete();
    setup(cfg, n, w[31:0]);
    if (n > 8'd4) wr(OFF_OUTW, w[63:32]);
    if (early) wr(OFF_CTRL, 32'h02);
    wr(OFF_CTRL, 32'h01);
    if (!early) wr(OFF_CTRL, 32'h02);
    wait_cnt(dones, b0 + 1, 20000);
    wait_idle();
    check(i2c_target_model_inst.rx_q.size(), {24'h0, n});
    for (int i = 0; i < n; i++) check(i2c_target_model_inst.rx_q[i], exp[8*i+:8]);
    check(blocks - k0, 1);
    rd_chk(OFF_MOVED, 32'hffff_ffff, {24'h0, n});
    rd_chk(OFF_STAT, 32'h39, 32'h0);
    check({30'h0, scl_oe_n, sda_oe_n}, 32'h3);
  endtask
  task automatic t_nack();
    int b0;
    b0 = dones;
    @(posedge clk) nack <= 1'b1;
    setup(32'h0000_0181, 8'd4, 32'h0403_0201);
    wr(OFF_CTRL, 32'h03);
    wait_cnt(dones, b0 + 1, 20000);
    wait_idle();
    rd_chk(OFF_STAT, 32'h39, 32'h08);
    check({30'h0, scl_oe_n, sda_oe_n}, 32'h3);
    @(posedge clk) nack <= 1'b0;
    // ten-bit header is not our target's address, so it goes unanswered
    setup(32'h0000_018a, 8'd4, 32'h0403_0201);
    wr(OFF_CTRL, 32'h03);
    wait_cnt(dones, b0 + 2, 20000);
    check(i2c_target_model_inst.sh, 8'hf6);
    wait_idle();
    rd_chk(OFF_STAT, 32'h39, 32'h08);
  endtask
  task automatic t_park();
    int b0;
    b0 = dones;
    setup(32'h0000_0192, 8'd4, 32'h0403_0201);
    wr(OFF_CTRL, 32'h03);
    wait_cnt(dones, b0 + 1, 4000);
    check({30'h0, scl_oe_n, sda_oe_n}, 32'h1);
    rd_chk(OFF_STAT, 32'h39, 32'h0);
    run_write(32'h0000_0182, 8'd4, 64'h4433_2211, 64'h4433_2211, 1'b1);
  endtask
  task automatic t_arb();
    int b0;
    b0 = dones;
    setup(32'h0001_0182, 8'd4, 32'h0403_0201);
    wr(OFF_ADR, 32'h0002_03da);
    @(posedge clk) clash <= 1'b1;
    wr(OFF_CTRL, 32'h03);
    wait_cnt(dones, b0 + 1, 2000);
    @(posedge clk) clash <= 1'b0;
    rd_chk(OFF_STAT, 32'h39, 32'h20);
  endtask
  task automatic t_read();
    int b0;
    logic [31:0] q;
    b0 = dones;
    setup(32'h0000_2182, 8'd8, 32'h0);
    wr(OFF_CTRL, 32'h01);
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 600; i++) begin
        bus(1'b0, OFF_STAT, 32'h0, q);
        if (q[2] === 1'b1) break;
        if (i == 599) bail();
      end
      check(q & 32'h39, 32'h01);
      rd_chk(OFF_INW, 32'hffff_ffff, 32'hc3c2_c1c0 + {4{8'h04 * k[7:0]}});
      wr(OFF_CTRL, 32'h04);
    end
    wait_cnt(dones, b0 + 1, 20000);
    wait_idle();
    rd_chk(OFF_MOVED, 32'hffff_ffff, 32'h8);
  endtask
  task automatic t_lock();
    int b0;
    int l0;
    b0 = dones;
    l0 = locks;
    setup(32'h0000_0181, 8'd4, 32'h0403_0201);
    @(posedge clk) hold <= 1'b1;
    wr(OFF_CTRL, 32'h03);
    wait_cnt(locks, l0 + 1, 6000);
    @(posedge clk) hold <= 1'b0;
    wait_cnt(dones, b0 + 1, 4000);
    rd_chk(OFF_STAT, 32'h19, 32'h10);
  endtask
  task automatic t_cancel();
    setup(32'h0000_0181, 8'd4, 32'h0403_0201);
    wr(OFF_CTRL, 32'h10);
    wr(OFF_CTRL, 32'h11);
    repeat (300) @(posedge clk);
    rd_chk(OFF_STAT, 32'h01, 32'h0);
    check({30'h0, scl_oe_n, sda_oe_n}, 32'h3);
    wr(OFF_CTRL, 32'h00);
    wr(OFF_CTRL, 32'h03);
    repeat (400) @(posedge clk);
    rd_chk(OFF_STAT, 32'h19, 32'h01);
    wr(OFF_CTRL, 32'h10);
    repeat (8) @(posedge clk);
    rd_chk(OFF_STAT, 32'h01, 32'h0);
    check({30'h0, scl_oe_n, sda_oe_n}, 32'h3);
    wr(OFF_CTRL, 32'h08);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    run_write(32'h0000_0182, 8'd6, {32'heeee_6655, 32'h4433_2211}, 64'h6655_4433_2211, 1'b0);
    run_write(32'h0000_81c2, 8'd4, 64'h4433_2211, 64'h1122_3344, 1'b1);
    run_write(32'h0000_4182, 8'd4, 64'h4433_2211, 64'h3344_1122, 1'b1);
    t_park();
    t_nack();
    t_arb();
    t_read();
    t_lock();
    t_cancel();
    report_and_stop();
  end
endmodule // i2c_master_buffered_bench
`default_nettype wire
